// *** protection_output_router_pkg.sv ***
// constants for the protection output router: register map, bits, resets
// assumes a 32-bit plain register port with byte addresses
package protection_output_router_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_ROUTE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_RELAYS = 8'h0c;
  localparam logic [7:0] OFS_STAGES = 8'h10;
  localparam logic [7:0] OFS_CONTROL = 8'h14;
  localparam logic [7:0] OFS_OC_COUNT = 8'h18;
  localparam logic [7:0] OFS_EF_COUNT = 8'h1c;

  // output_route_switches: switch n sits at bit n (bits 2..8)
  localparam int ROUTE_W = 9;
  localparam int SW2_BIT = 2;
  localparam int SW3_BIT = 3;
  localparam int SW4_BIT = 4;
  localparam int SW5_BIT = 5;
  localparam int SW6_BIT = 6;
  localparam int SW7_BIT = 7;
  localparam int SW8_BIT = 8;
  localparam logic [8:0] ROUTE_USED = 9'h1fc;
  localparam logic [8:0] ROUTE_RESET = 9'h1fc;

  // event status / mask bits
  localparam int EVT_W = 5;
  localparam int EVT_OC_START = 0;
  localparam int EVT_OC_TRIP = 1;
  localparam int EVT_EF_START = 2;
  localparam int EVT_EF_TRIP = 3;
  localparam int EVT_FAULT = 4;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // relay readback bits
  localparam int RLY_A = 0;
  localparam int RLY_B = 1;
  localparam int RLY_C = 2;
  localparam int RLY_D = 3;
  localparam int RLY_E = 4;
  localparam int RLY_F = 5;

  // stage readback bits
  localparam int STG_LOW_START = 0;
  localparam int STG_LOW_TRIP = 1;
  localparam int STG_HIGH_START = 2;
  localparam int STG_HIGH_TRIP = 3;
  localparam int STG_EF_START = 4;
  localparam int STG_EF_TRIP = 5;
  localparam int STG_SUPPLY_LOST = 6;
  localparam int STG_FAULT_PIN = 7;

  // control bits
  localparam int CTL_FORCE_FAULT = 0;
  localparam logic [0:0] CONTROL_RESET = 1'h0;

  localparam int COUNT_W = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

endpackage : protection_output_router_pkg

// *** level_sync.sv ***
// two flip-flop synchroniser for levels arriving from pins
// assumes ref_clk domain and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : level_sync
`default_nettype wire

// *** event_status.sv ***
// sticky event status with write-one-to-clear, mask and level interrupt
// assumes ref_clk domain; set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module event_status
  import protection_output_router_pkg::*;
#(
  parameter int WIDTH = EVT_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] event_set,
  input wire logic clear_wr,
  input wire logic mask_wr,
  input wire logic [WIDTH-1:0] wr_bits,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);
  logic [WIDTH-1:0] status_ff;
  logic [WIDTH-1:0] mask_ff;
  logic irq_ff;
  logic [WIDTH-1:0] clear_bits;
  logic [WIDTH-1:0] nxt_status;
  logic [WIDTH-1:0] nxt_mask;

  assign clear_bits = clear_wr ? wr_bits : '0;
  assign nxt_status = (status_ff & ~clear_bits) | event_set;
  assign nxt_mask = mask_wr ? wr_bits : mask_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      status_ff <= WIDTH'(STATUS_RESET);
      mask_ff <= WIDTH'(MASK_RESET);
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= |(nxt_status & nxt_mask);
    end
  end

  assign status = status_ff;
  assign mask = mask_ff;
  assign irq = irq_ff;
endmodule : event_status
`default_nettype wire

// *** protection_output_router.sv ***
// output relay routing matrix of an overcurrent and earth-fault unit
// assumes stage start/trip levels come from logic on ref_clk; supply and
// fault pins are asynchronous; registers on a plain strobe port
//
// Contract
// [R01] relay F always follows low-set and high-set overcurrent starts
// [R02] relay A always follows low-set and high-set overcurrent trips
// [R03] relay B always follows the earth-fault trip
// [R04] switch 2 set: earth-fault start also drives relay D
// [R05] switch 3 set: overcurrent starts also drive relay D
// [R06] switches 4,5,6 set: earth-fault trip also drives relay D, C, A
// [R07] switch 7 set: overcurrent trips drive C; switch 8: drive B
// [R08] alarm relay energised when healthy; drops on supply loss or fault
// [R09] signal output asserts on any overcurrent or earth-fault trip
// [R10] first start output: earth-fault trip or any stage start
// [R11] second start output: low-set or high-set overcurrent start
// [R12] both trip outputs can carry every stage trip
// [R13] relays A and B each can command a breaker directly
// [R14] all seven route switches default to one
`timescale 1ns/1ps
`default_nettype none
module protection_output_router
  import protection_output_router_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  // protection stage levels
  input wire logic low_start,
  input wire logic low_trip,
  input wire logic high_start,
  input wire logic high_trip,
  input wire logic earth_fault_stage_start,
  input wire logic earth_fault_stage_trip,
  // supervision pins
  input wire logic supply_lost,
  input wire logic internal_fault,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // output relays and interrupt
  output logic trip_relay_a,
  output logic trip_relay_b,
  output logic signal_relay_c,
  output logic start_relay_d,
  output logic internal_fault_alarm,
  output logic start_relay_f,
  output logic irq
);

  function automatic logic [COUNT_W-1:0] count_up(
    input logic [COUNT_W-1:0] value
  );
    logic [COUNT_W-1:0] result;
    result = value;
    if (value != '1) begin
      result = value + COUNT_W'(1);
    end
    return result;
  endfunction : count_up

  // rising edge of a level against its value one cycle back
  function automatic logic rise(
    input logic now_level,
    input logic last_level
  );
    return now_level && !last_level;
  endfunction : rise

  // saturating trip count: write clears, an edge still counts
  function automatic logic [COUNT_W-1:0] next_count(
    input logic edge_seen,
    input logic clear,
    input logic [COUNT_W-1:0] value
  );
    logic [COUNT_W-1:0] base;
    base = clear ? COUNT_RESET : value;
    if (edge_seen) begin
      base = count_up(base);
    end
    return base;
  endfunction : next_count

  // register decode
  wire sel_route = reg_addr == OFS_ROUTE;
  wire sel_status = reg_addr == OFS_STATUS;
  wire sel_mask = reg_addr == OFS_MASK;
  wire sel_relays = reg_addr == OFS_RELAYS;
  wire sel_stages = reg_addr == OFS_STAGES;
  wire sel_control = reg_addr == OFS_CONTROL;
  wire sel_oc_count = reg_addr == OFS_OC_COUNT;
  wire sel_ef_count = reg_addr == OFS_EF_COUNT;
  wire wr_route = reg_wr && sel_route;
  wire wr_status = reg_wr && sel_status;
  wire wr_mask = reg_wr && sel_mask;
  wire wr_control = reg_wr && sel_control;
  wire wr_oc_count = reg_wr && sel_oc_count;
  wire wr_ef_count = reg_wr && sel_ef_count;

  // supervision pins through synchroniser
  logic [1:0] pin_sync;
  level_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({internal_fault, supply_lost}),
    .sync_out(pin_sync)
  );
  wire supply_lost_s = pin_sync[0];
  wire fault_pin_s = pin_sync[1];

  // software registers
  logic [ROUTE_W-1:0] output_route_switches_ff;
  logic [0:0] control_ff;
  logic [ROUTE_W-1:0] nxt_route;
  logic [0:0] nxt_control;

  assign nxt_route = wr_route ?
    (reg_wdata[ROUTE_W-1:0] & ROUTE_USED) : output_route_switches_ff;
  assign nxt_control = wr_control ? reg_wdata[0:0] : control_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      output_route_switches_ff <= ROUTE_RESET; // R14
      control_ff <= CONTROL_RESET;
    end else begin
      output_route_switches_ff <= nxt_route;
      control_ff <= nxt_control;
    end
  end

  wire sw2 = output_route_switches_ff[SW2_BIT];
  wire sw3 = output_route_switches_ff[SW3_BIT];
  wire sw4 = output_route_switches_ff[SW4_BIT];
  wire sw5 = output_route_switches_ff[SW5_BIT];
  wire sw6 = output_route_switches_ff[SW6_BIT];
  wire sw7 = output_route_switches_ff[SW7_BIT];
  wire sw8 = output_route_switches_ff[SW8_BIT];
  wire force_fault = control_ff[CTL_FORCE_FAULT];

  // combined stage signals
  wire oc_start = low_start || high_start;
  wire stage_trip_signal_oc = low_trip || high_trip;
  wire stage_trip_signal_ef = earth_fault_stage_trip;
  wire ef_start = earth_fault_stage_start;

  // routing matrix
  wire route_f = oc_start; // R01 R11
  wire route_a = stage_trip_signal_oc // R02
    || (sw6 && stage_trip_signal_ef); // R06 R12
  wire route_b = stage_trip_signal_ef // R03
    || (sw8 && stage_trip_signal_oc); // R07 R12
  wire route_c = (sw5 && stage_trip_signal_ef) // R06 R09
    || (sw7 && stage_trip_signal_oc); // R07 R09
  wire route_d = (sw2 && ef_start) // R04 R10
    || (sw3 && oc_start) // R05 R10
    || (sw4 && stage_trip_signal_ef); // R06 R10
  wire healthy = !supply_lost_s && !fault_pin_s && !force_fault;

  // output relay flops, de-energised during reset
  logic relay_a_ff;
  logic relay_b_ff;
  logic relay_c_ff;
  logic relay_d_ff;
  logic relay_e_ff;
  logic relay_f_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      relay_a_ff <= 1'b0;
      relay_b_ff <= 1'b0;
      relay_c_ff <= 1'b0;
      relay_d_ff <= 1'b0;
      relay_e_ff <= 1'b0;
      relay_f_ff <= 1'b0;
    end else begin
      relay_a_ff <= route_a; // R13
      relay_b_ff <= route_b; // R13
      relay_c_ff <= route_c;
      relay_d_ff <= route_d;
      relay_e_ff <= healthy; // R08
      relay_f_ff <= route_f;
    end
  end

  assign trip_relay_a = relay_a_ff;
  assign trip_relay_b = relay_b_ff;
  assign signal_relay_c = relay_c_ff;
  assign start_relay_d = relay_d_ff;
  assign internal_fault_alarm = relay_e_ff;
  assign start_relay_f = relay_f_ff;

  // event edges
  logic oc_start_d_ff;
  logic oc_trip_d_ff;
  logic ef_start_d_ff;
  logic ef_trip_d_ff;
  logic healthy_d_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      oc_start_d_ff <= 1'b0;
      oc_trip_d_ff <= 1'b0;
      ef_start_d_ff <= 1'b0;
      ef_trip_d_ff <= 1'b0;
      healthy_d_ff <= 1'b1;
    end else begin
      oc_start_d_ff <= oc_start;
      oc_trip_d_ff <= stage_trip_signal_oc;
      ef_start_d_ff <= ef_start;
      ef_trip_d_ff <= stage_trip_signal_ef;
      healthy_d_ff <= healthy;
    end
  end

  wire oc_start_rise = rise(oc_start, oc_start_d_ff);
  wire oc_trip_rise = rise(stage_trip_signal_oc, oc_trip_d_ff);
  wire ef_start_rise = rise(ef_start, ef_start_d_ff);
  wire ef_trip_rise = rise(stage_trip_signal_ef, ef_trip_d_ff);
  wire fault_rise = rise(!healthy, !healthy_d_ff);

  logic [EVT_W-1:0] event_set;
  assign event_set[EVT_OC_START] = oc_start_rise;
  assign event_set[EVT_OC_TRIP] = oc_trip_rise;
  assign event_set[EVT_EF_START] = ef_start_rise;
  assign event_set[EVT_EF_TRIP] = ef_trip_rise;
  assign event_set[EVT_FAULT] = fault_rise;

  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic irq_level;

  event_status #(
    .WIDTH(EVT_W)
  ) u_event_status (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .event_set(event_set),
    .clear_wr(wr_status),
    .mask_wr(wr_mask),
    .wr_bits(reg_wdata[EVT_W-1:0]),
    .status(status),
    .mask(mask),
    .irq(irq_level)
  );

  assign irq = irq_level;

  // trip counters, saturating; write clears, count wins
  logic [COUNT_W-1:0] oc_count_ff;
  logic [COUNT_W-1:0] ef_count_ff;
  logic [COUNT_W-1:0] nxt_oc_count;
  logic [COUNT_W-1:0] nxt_ef_count;

  assign nxt_oc_count = next_count(oc_trip_rise, wr_oc_count, oc_count_ff);
  assign nxt_ef_count = next_count(ef_trip_rise, wr_ef_count, ef_count_ff);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      oc_count_ff <= COUNT_RESET;
      ef_count_ff <= COUNT_RESET;
    end else begin
      oc_count_ff <= nxt_oc_count;
      ef_count_ff <= nxt_ef_count;
    end
  end

  // readback words
  logic [DATA_W-1:0] relays_word;
  logic [DATA_W-1:0] stages_word;

  always_comb begin
    relays_word = '0;
    relays_word[RLY_A] = relay_a_ff;
    relays_word[RLY_B] = relay_b_ff;
    relays_word[RLY_C] = relay_c_ff;
    relays_word[RLY_D] = relay_d_ff;
    relays_word[RLY_E] = relay_e_ff;
    relays_word[RLY_F] = relay_f_ff;
  end

  always_comb begin
    stages_word = '0;
    stages_word[STG_LOW_START] = low_start;
    stages_word[STG_LOW_TRIP] = low_trip;
    stages_word[STG_HIGH_START] = high_start;
    stages_word[STG_HIGH_TRIP] = high_trip;
    stages_word[STG_EF_START] = earth_fault_stage_start;
    stages_word[STG_EF_TRIP] = earth_fault_stage_trip;
    stages_word[STG_SUPPLY_LOST] = supply_lost_s;
    stages_word[STG_FAULT_PIN] = fault_pin_s;
  end

  // read mux, unmapped reads zero
  wire [DATA_W-1:0] rd_route = sel_route ?
    DATA_W'(output_route_switches_ff) : '0;
  wire [DATA_W-1:0] rd_status = sel_status ? DATA_W'(status) : '0;
  wire [DATA_W-1:0] rd_mask = sel_mask ? DATA_W'(mask) : '0;
  wire [DATA_W-1:0] rd_relays = sel_relays ? relays_word : '0;
  wire [DATA_W-1:0] rd_stages = sel_stages ? stages_word : '0;
  wire [DATA_W-1:0] rd_control = sel_control ? DATA_W'(control_ff) : '0;
  wire [DATA_W-1:0] rd_oc = sel_oc_count ? DATA_W'(oc_count_ff) : '0;
  wire [DATA_W-1:0] rd_ef = sel_ef_count ? DATA_W'(ef_count_ff) : '0;
  wire [DATA_W-1:0] rd_any = rd_route | rd_status | rd_mask | rd_relays
    | rd_stages | rd_control | rd_oc | rd_ef;
  wire [DATA_W-1:0] nxt_rdata = reg_rd ? rd_any : '0;

  logic [DATA_W-1:0] rdata_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : protection_output_router
`default_nettype wire

// *** router_properties.sv ***
// checker: relay routing and alarm timing seen at the router ports
// assumes stage inputs change just after rising edges of ref_clk
`timescale 1ns/1ps
`default_nettype none
module router_properties
  import protection_output_router_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic low_start,
  input wire logic low_trip,
  input wire logic high_start,
  input wire logic high_trip,
  input wire logic earth_fault_stage_start,
  input wire logic earth_fault_stage_trip,
  input wire logic supply_lost,
  input wire logic internal_fault,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic trip_relay_a,
  input wire logic trip_relay_b,
  input wire logic signal_relay_c,
  input wire logic start_relay_d,
  input wire logic internal_fault_alarm,
  input wire logic start_relay_f
);
  logic [ROUTE_W-1:0] route_ff;
  logic [ROUTE_W-1:0] nxt_route;
  wire logic oc_s = low_start | high_start;
  wire logic oc_t = low_trip | high_trip;
  wire logic ef_s = earth_fault_stage_start;
  wire logic ef_t = earth_fault_stage_trip;
  wire logic route_wr = reg_wr && (reg_addr == OFS_ROUTE);
  assign nxt_route = route_wr ? (reg_wdata[ROUTE_W-1:0] & ROUTE_USED)
                              : route_ff;
  always_ff @(posedge ref_clk) begin
    if (!resetn) route_ff <= ROUTE_RESET;
    else route_ff <= nxt_route;
  end
  logic ctl_ff;
  logic nxt_ctl;
  wire logic ctl_wr = reg_wr && (reg_addr == OFS_CONTROL);
  assign nxt_ctl = ctl_wr ? reg_wdata[CTL_FORCE_FAULT] : ctl_ff;
  always_ff @(posedge ref_clk) begin
    if (!resetn) ctl_ff <= CONTROL_RESET;
    else ctl_ff <= nxt_ctl;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence supply_down; supply_lost [*3]; endsequence
  sequence fault_down; internal_fault [*3]; endsequence
  sequence healthy_run;
    (!supply_lost && !internal_fault && !ctl_ff) [*4];
  endsequence
  relay_f_a: assert property ($past(resetn) |->
    start_relay_f == $past(oc_s)) else $error("relay f mismatch");
  relay_a_a: assert property ($past(resetn) |->
    trip_relay_a == $past(oc_t | (route_ff[SW6_BIT] & ef_t)))
    else $error("relay a mismatch");
  relay_b_a: assert property ($past(resetn) |->
    trip_relay_b == $past(ef_t | (route_ff[SW8_BIT] & oc_t)))
    else $error("relay b mismatch");
  relay_c_a: assert property ($past(resetn) |->
    signal_relay_c == $past((route_ff[SW5_BIT] & ef_t)
    | (route_ff[SW7_BIT] & oc_t))) else $error("relay c mismatch");
  relay_d_a: assert property ($past(resetn) |->
    start_relay_d == $past((route_ff[SW2_BIT] & ef_s)
    | (route_ff[SW3_BIT] & oc_s) | (route_ff[SW4_BIT] & ef_t)))
    else $error("relay d mismatch");
  supply_drop_a: assert property (supply_down |=>
    !internal_fault_alarm) else $error("alarm held on supply loss");
  fault_drop_a: assert property (fault_down |=>
    !internal_fault_alarm) else $error("alarm held on fault");
  healthy_hold_a: assert property (healthy_run |=>
    internal_fault_alarm) else $error("alarm while healthy");
  force_drop_a: assert property (ctl_ff |=>
    !internal_fault_alarm) else $error("alarm held on forced fault");
endmodule : router_properties
bind protection_output_router router_properties i_props (.*);
`default_nettype wire

// *** breaker_model.sv ***
// circuit breaker: opens once its coil has been energised long enough
// assumes the coil is a trip relay output on ref_clk
`timescale 1ns/1ps
`default_nettype none
module breaker_model #(
  parameter int OPEN_DELAY = 1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic coil,
  input wire logic reclose,
  output logic breaker_open
);
  int hold_cnt;
  always @(posedge ref_clk) begin
    if (!resetn || reclose) begin
      hold_cnt <= 0;
      breaker_open <= 1'b0;
    end else if (coil) begin
      hold_cnt <= hold_cnt + 1;
      if (hold_cnt + 1 >= OPEN_DELAY) breaker_open <= 1'b1;
    end
  end
endmodule : breaker_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the protection output router
// assumes a 200 MHz ref_clk and breakers on relays a and b
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import protection_output_router_pkg::*;
  logic ref_clk, resetn, reg_wr, reg_rd, supply_lost, internal_fault;
  logic reclose;
  logic [5:0] stg;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, rdata;
  wire logic [31:0] reg_rdata;
  wire logic a, b, c, d, e, f, irq, open1, open2;
  wire logic [31:0] relays = {26'h0, f, e, d, c, b, a};
  int errors = 0;
  int cmp_count = 0;
  protection_output_router i_dut (.ref_clk(ref_clk), .resetn(resetn),
    .low_start(stg[0]), .low_trip(stg[1]), .high_start(stg[2]),
    .high_trip(stg[3]), .earth_fault_stage_start(stg[4]),
    .earth_fault_stage_trip(stg[5]), .supply_lost(supply_lost),
    .internal_fault(internal_fault), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trip_relay_a(a), .trip_relay_b(b),
    .signal_relay_c(c), .start_relay_d(d), .internal_fault_alarm(e),
    .start_relay_f(f), .irq(irq));
  breaker_model #(.OPEN_DELAY(1)) i_brk1 (.ref_clk(ref_clk),
    .resetn(resetn), .coil(a), .reclose(reclose), .breaker_open(open1));
  breaker_model #(.OPEN_DELAY(4)) i_brk2 (.ref_clk(ref_clk),
    .resetn(resetn), .coil(b), .reclose(reclose), .breaker_open(open2));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rdata = reg_rdata;
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_n
  function automatic logic [5:0] exp_rl(logic [8:0] r, logic [5:0] s);
    logic os, ot;
    os = s[0] | s[2];
    ot = s[1] | s[3];
    return {os, 1'b1, (r[2] & s[4]) | (r[3] & os) | (r[4] & s[5]),
      (r[5] & s[5]) | (r[7] & ot), s[5] | (r[8] & ot), ot | (r[6] & s[5])};
  endfunction : exp_rl
  task automatic test_defaults;
    rd(OFS_ROUTE);
    check(rdata, 32'h000001fc);
    wr(8'h40, 32'hffffffff);
    rd(8'h40);
    check(rdata, 32'h00000000);
    $display("defaults done");
  endtask : test_defaults
  task automatic test_routes;
    logic [8:0] r;
    logic [5:0] s;
    for (int i = 0; i < 9; i++) begin
      r = (i == 0) ? 9'h000 : (i == 8) ? 9'h1fc : 9'(1 << (i + 1));
      wr(OFS_ROUTE, {23'h0, r});
      for (int p = 0; p < 7; p++) begin
        s = (p < 6) ? 6'(1 << p) : 6'h3f;
        stg <= s;
        wait_n(2);
        check(relays, {26'h0, exp_rl(r, s)});
      end
    end
    rd(OFS_RELAYS);
    check(rdata, {26'h0, exp_rl(9'h1fc, 6'h3f)});
    stg <= 6'h00;
    $display("routes done");
  endtask : test_routes
  task automatic test_alarm;
    for (int j = 0; j < 2; j++) begin
      wr(OFS_STATUS, 32'h10);
      @(posedge ref_clk);
      if (j == 0) supply_lost <= 1'b1;
      else internal_fault <= 1'b1;
      wait_n(4);
      check({31'h0, e}, 32'h0);
      rd(OFS_STATUS);
      check({27'h0, rdata[4:0] & 5'h10}, 32'h10);
      check({31'h0, irq}, 32'h0);
      supply_lost <= 1'b0;
      internal_fault <= 1'b0;
      wait_n(4);
      check({31'h0, e}, 32'h1);
    end
    $display("alarm done");
  endtask : test_alarm
  task automatic test_irq;
    wr(OFS_STATUS, 32'h1f);
    wr(OFS_MASK, 32'h02);
    stg <= 6'h02;
    wait_n(2);
    check({31'h0, irq}, 32'h1);
    stg <= 6'h00;
    wr(OFS_STATUS, 32'h02);
    wait_n(1);
    check({31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h00);
    stg <= 6'h02;
    wait_n(2);
    check({31'h0, irq}, 32'h0);
    rd(OFS_STATUS);
    check(rdata, 32'h02);
    stg <= 6'h00;
    $display("irq done");
  endtask : test_irq
  task automatic test_breakers;
    @(posedge ref_clk);
    reclose <= 1'b1;
    @(posedge ref_clk);
    reclose <= 1'b0;
    stg <= 6'h02;
    wait_n(3);
    check({30'h0, open2, open1}, 32'h1);
    wait_n(3);
    check({30'h0, open2, open1}, 32'h3);
    stg <= 6'h00;
    $display("breakers done");
  endtask : test_breakers
  task automatic test_extras;
    wr(OFS_STATUS, 32'h1f);
    wr(OFS_CONTROL, 32'h1);
    wait_n(2);
    check({31'h0, e}, 32'h0);
    rd(OFS_STATUS);
    check(rdata, 32'h10);
    wr(OFS_CONTROL, 32'h0);
    wait_n(2);
    check({31'h0, e}, 32'h1);
    wr(OFS_OC_COUNT, 32'h0);
    wr(OFS_EF_COUNT, 32'h0);
    for (int k = 0; k < 3; k++) begin
      stg <= 6'h02;
      wait_n(1);
      stg <= (k < 2) ? 6'h20 : 6'h00;
      wait_n(1);
    end
    stg <= 6'h15;
    rd(OFS_STAGES);
    check(rdata, 32'h15);
    rd(OFS_OC_COUNT);
    check(rdata, 32'h3);
    rd(OFS_EF_COUNT);
    check(rdata, 32'h2);
    stg <= 6'h00;
    wr(OFS_ROUTE, 32'h0);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(OFS_ROUTE);
    check(rdata, 32'h000001fc);
    check({31'h0, e}, 32'h1);
    $display("extras done");
  endtask : test_extras
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    stg = 6'h00;
    supply_lost = 1'b0;
    internal_fault = 1'b0;
    reclose = 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    test_defaults();
    test_routes();
    test_alarm();
    test_irq();
    test_breakers();
    test_extras();
    stop_test();
  end
  initial begin
    #50000;
    errors++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
